// file: rtl/lgpc_pkg.sv
// Purpose: constants for the global line and pulse-shape config bank
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   printed offsets are indexes; byte address is four times index
package lgpc_pkg;
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned CH_W        = 3;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned REG_W       = 8;

  // register indexes
  localparam logic [ADDR_W-1:0] IDX_GLOBAL  = 8'h0f;
  localparam logic [ADDR_W-1:0] IDX_CHSEL   = 8'h10;
  localparam logic [ADDR_W-1:0] IDX_SHAPE   = 8'h11;
  localparam logic [ADDR_W-1:0] IDX_WAVEADR = 8'h17;

  localparam logic [REG_W-1:0]  RST_GLOBAL  = 8'h00;
  localparam logic [REG_W-1:0]  RST_CHSEL   = 8'h00;
  localparam logic [REG_W-1:0]  RST_SHAPE   = 8'h00;
  localparam logic [REG_W-1:0]  RST_WAVEADR = 8'h00;

  // global fields
  localparam int unsigned G_AUTOINC = 7;
  localparam int unsigned G_AISEN   = 6;
  localparam int unsigned G_RSVD    = 5;
  localparam int unsigned G_CODE    = 4;
  localparam int unsigned G_FIFO    = 3;
  localparam int unsigned G_CORNER  = 2;
  localparam int unsigned G_POS_HI  = 1;
  localparam int unsigned G_POS_LO  = 0;
  localparam logic [1:0]  POS_TX    = 2'h1;
  localparam logic [1:0]  POS_RX    = 2'h3;

  // shape data fields
  localparam int unsigned S_IMP     = 4;
  localparam int unsigned S_CODE_HI = 3;
  localparam int unsigned S_CODE_W  = 4;
  localparam logic [REG_W-1:0] SHAPE_MASK = 8'h1f;
  localparam logic [REG_W-1:0] CHSEL_MASK = 8'h07;

  // waveform address fields
  localparam int unsigned WA_CH_LO  = 5;
  localparam int unsigned WA_PA_W   = 5;

  // shape codes and samples per unit interval
  localparam logic [3:0] SHP_E1_120   = 4'h0;
  localparam logic [3:0] SHP_DS1_US   = 4'h1;
  localparam logic [3:0] SHP_DS1_0DB  = 4'h2;
  localparam logic [3:0] SHP_LEN_LO   = 4'h3;
  localparam logic [3:0] SHP_LEN_HI   = 4'h7;
  localparam logic [3:0] SHP_E1_75    = 4'h8;
  localparam logic [4:0] SPU_E1       = 5'h0c;
  localparam logic [4:0] SPU_DS1      = 5'h0e;
  localparam logic [4:0] SPU_LEN      = 5'h0d;
  localparam logic [4:0] SPU_NONE     = 5'h00;

  localparam logic [6:0] DEPTH_SHORT  = 7'h20;
  localparam logic [6:0] DEPTH_LONG   = 7'h40;

  typedef enum logic [1:0] {
    LGPC_IDLE   = 2'b00,
    LGPC_ACCESS = 2'b01
  } lgpc_state_t;
endpackage

// file: rtl/lgpc_shape_bank.sv
// Purpose: eight per-channel impedance and shape-code copies
// Assumes: one write strobe per cycle, channel index from select register
// Notes:   all channels readable at once for the line side
module lgpc_shape_bank
  import lgpc_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      wr_en,
  input  wire logic [CH_W-1:0]           wr_ch,
  input  wire logic [REG_W-1:0]          wr_data,
  input  wire logic [CH_W-1:0]           rd_ch,
  output      logic [REG_W-1:0]          rd_data,
  output      logic [NUM_CH*REG_W-1:0]   all_data
);
  logic [REG_W-1:0] cfg_q [NUM_CH];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          cfg_q[g] <= RST_SHAPE;
        end else if (wr_en && (wr_ch == CH_W'(g))) begin
          cfg_q[g] <= wr_data & SHAPE_MASK;
        end
      end
      assign all_data[g*REG_W +: REG_W] = cfg_q[g];
    end
  endgenerate

  assign rd_data = cfg_q[rd_ch];
endmodule

// file: rtl/lgpc_regs.sv
// Purpose: global line config and indirect pulse-shape config over apb
// Assumes: los_ch and phase_access come from logic on clk_sys
// Notes:   zero-wait apb slave; unmapped reads return zero with pslverr
//
// Operation
// - global register clears on any reset
// - autoincrement advances phase address after access
// - alarm insertion on loss when enabled
// - bit 4 selects ami or b8zs/hdb3
// - bit 3 selects 32 or 64 depth
// - bit 2 selects jitter corner
// - position field: off, transmit, receive
// - channel select names target channel
// - data register reaches selected channel only
// - bit 4 selects internal impedance matching
// - codes 0000 and 1000 are e1, 12 samples
// - codes 0001, 0010 are ds1, 14 samples
// - codes 0011 to 0111 cable lengths, 13 samples
// - waveform address: channel high, sample low
//
// Implementation choice: the APB register port.
module lgpc_regs
  import lgpc_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W+1:0]         paddr,
  input  wire logic [DATA_W-1:0]         pwdata,
  input  wire logic [3:0]                pstrb,
  output      logic [DATA_W-1:0]         prdata,
  output      logic                      pready,
  output      logic                      pslverr,
  input  wire logic [NUM_CH-1:0]         los_ch,
  input  wire logic                      phase_access,
  output      logic [NUM_CH-1:0]         rx_alarm_insert,
  output      logic                      line_code_select,
  output      logic [6:0]                jitter_fifo_depth,
  output      logic                      jitter_corner_select,
  output      logic                      jitter_en_tx,
  output      logic                      jitter_en_rx,
  output      logic [2:0]                waveform_target_channel,
  output      logic [4:0]                phase_sample_address,
  output      logic [NUM_CH-1:0]         impedance_internal_select,
  output      logic [NUM_CH*4-1:0]       pulse_shape_code,
  output      logic [NUM_CH*5-1:0]       samples_per_ui
);
  logic [REG_W-1:0]        global_line_config_q;
  logic [REG_W-1:0]        shape_channel_select_q;
  logic [REG_W-1:0]        wave_addr_q;
  logic [REG_W-1:0]        wave_addr_d;
  logic [DATA_W-1:0]       prdata_q;
  logic                    pslverr_q;
  lgpc_state_t             state_q;
  lgpc_state_t             state_d;
  logic [REG_W-1:0]        shape_rd;
  logic [NUM_CH*REG_W-1:0] shape_all;

  function automatic logic [4:0] spu_of(input logic [3:0] code);
    logic [4:0] r;
    r = SPU_NONE;
    if (code == SHP_E1_120 || code == SHP_E1_75) begin
      r = SPU_E1;
    end else if (code == SHP_DS1_US || code == SHP_DS1_0DB) begin
      r = SPU_DS1;
    end else if (code >= SHP_LEN_LO && code <= SHP_LEN_HI) begin
      r = SPU_LEN;
    end
    return r;
  endfunction

  // aligned word match against one register index
  function automatic logic hit_of(input logic [ADDR_W+1:0] a,
                                  input logic [ADDR_W-1:0] index);
    logic r;
    r = 1'b0;
    if (a[1:0] == 2'h0) begin
      r = (a[ADDR_W+1:2] == index);
    end
    return r;
  endfunction

  wire              hit_g    = hit_of(paddr, IDX_GLOBAL);
  wire              hit_c    = hit_of(paddr, IDX_CHSEL);
  wire              hit_s    = hit_of(paddr, IDX_SHAPE);
  wire              hit_w    = hit_of(paddr, IDX_WAVEADR);
  wire              mapped   = hit_g | hit_c | hit_s | hit_w;
  wire              setup    = psel && !penable;
  wire              acc      = psel && penable && (state_q == LGPC_ACCESS);
  wire              wr_lane0 = acc && pwrite && pstrb[0];
  wire              wr_g     = wr_lane0 && hit_g;
  wire              wr_c     = wr_lane0 && hit_c;
  wire              wr_s     = wr_lane0 && hit_s;
  wire              wr_w     = wr_lane0 && hit_w;
  wire [CH_W-1:0]   sel_ch   = shape_channel_select_q[CH_W-1:0];

  // global register fields shared by all channels
  wire              autoinc  = global_line_config_q[G_AUTOINC];
  wire              alarm_en = global_line_config_q[G_AISEN];
  wire              code_ami = global_line_config_q[G_CODE];
  wire              fifo_64  = global_line_config_q[G_FIFO];
  wire              corner   = global_line_config_q[G_CORNER];
  wire [1:0]        jpos     = global_line_config_q[G_POS_HI:G_POS_LO];

  // waveform address split: target channel high, sample address low
  wire [CH_W-1:0]    wa_chan = wave_addr_q[REG_W-1:WA_CH_LO];
  wire [WA_PA_W-1:0] wa_samp = wave_addr_q[WA_PA_W-1:0];
  wire [WA_PA_W-1:0] wa_next = wa_samp + WA_PA_W'(1);
  wire               wa_step = autoinc && phase_access;

  // read words, zero when not addressed
  wire [REG_W-1:0]  rd_glob  = hit_g ? global_line_config_q : '0;
  wire [REG_W-1:0]  rd_chs   = hit_c ? shape_channel_select_q : '0;
  wire [REG_W-1:0]  rd_shp   = hit_s ? shape_rd : '0;
  wire [REG_W-1:0]  rd_wav   = hit_w ? wave_addr_q : '0;
  wire [REG_W-1:0]  rd_mux   = rd_glob | rd_chs | rd_shp | rd_wav;

  lgpc_shape_bank u_bank (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .wr_en    (wr_s),
    .wr_ch    (sel_ch),
    .wr_data  (pwdata[REG_W-1:0]),
    .rd_ch    (sel_ch),
    .rd_data  (shape_rd),
    .all_data (shape_all)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      LGPC_IDLE: begin
        if (setup) begin
          state_d = LGPC_ACCESS;
        end
      end
      LGPC_ACCESS: begin
        if (!psel || penable) begin
          state_d = LGPC_IDLE;
        end
      end
      default: begin
        state_d = LGPC_IDLE;
      end
    endcase
  end

  // a write loads both fields; on a step the channel bits are held and the sample address advances
  always_comb begin
    wave_addr_d = wave_addr_q;
    if (wr_w) begin
      wave_addr_d = pwdata[REG_W-1:0];
    end else if (wa_step) begin
      wave_addr_d = {wa_chan, wa_next};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= LGPC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      global_line_config_q <= RST_GLOBAL;
    end else if (wr_g) begin
      global_line_config_q <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shape_channel_select_q <= RST_CHSEL;
    end else if (wr_c) begin
      shape_channel_select_q <= pwdata[REG_W-1:0] & CHSEL_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wave_addr_q <= RST_WAVEADR;
    end else begin
      wave_addr_q <= wave_addr_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, rd_mux};
      pslverr_q <= !mapped;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  assign line_code_select = code_ami;
  assign jitter_fifo_depth = fifo_64 ? DEPTH_LONG : DEPTH_SHORT;
  assign jitter_corner_select = corner;
  assign jitter_en_tx = (jpos == POS_TX);
  assign jitter_en_rx = (jpos == POS_RX);

  assign waveform_target_channel = wa_chan;
  assign phase_sample_address    = wa_samp;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_out
      wire [REG_W-1:0]    ch_cfg  = shape_all[c*REG_W +: REG_W];
      wire [S_CODE_W-1:0] ch_code = ch_cfg[S_CODE_HI:0];
      assign rx_alarm_insert[c] = los_ch[c] & alarm_en;
      assign impedance_internal_select[c] = ch_cfg[S_IMP];
      assign pulse_shape_code[c*S_CODE_W +: S_CODE_W] = ch_code;
      assign samples_per_ui[c*5 +: 5] = spu_of(ch_code);
    end
  endgenerate
endmodule

// file: sim/lgpc_regs_asserts.sv
// Purpose: port checks on the global and pulse-shape config bank
// Assumes: apb writes land at the access-phase edge
// Notes:   bound to every lgpc_regs instance
module lgpc_regs_asserts
  import lgpc_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    nrst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [ADDR_W+1:0]       paddr,
  input wire logic [DATA_W-1:0]       pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic [NUM_CH-1:0]       los_ch,
  input wire logic                    phase_access,
  input wire logic [NUM_CH-1:0]       rx_alarm_insert,
  input wire logic                    line_code_select,
  input wire logic [6:0]              jitter_fifo_depth,
  input wire logic                    jitter_en_tx,
  input wire logic                    jitter_en_rx,
  input wire logic [4:0]              phase_sample_address,
  input wire logic [NUM_CH*4-1:0]     pulse_shape_code,
  input wire logic [NUM_CH*5-1:0]     samples_per_ui
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  wire       wr_g = psel && penable && pwrite && pstrb[0] && paddr == 10'h3c;
  wire       wr_w = psel && penable && pwrite && pstrb[0] && paddr == 10'h5c;
  wire [3:0] c0   = pulse_shape_code[3:0];
  a_code_follow: assert property (wr_g |=>
    line_code_select == $past(pwdata[4])) else $error("line code not updated");
  a_depth_follow: assert property (wr_g |=>
    jitter_fifo_depth == ($past(pwdata[3]) ? 7'h40 : 7'h20)) else $error("depth wrong");
  a_pos_decode: assert property (wr_g |=>
    {jitter_en_rx, jitter_en_tx} == {$past(pwdata[1:0]) == 2'h3, $past(pwdata[1:0]) == 2'h1})
    else $error("position wrong");
  a_pos_excl: assert property (!(jitter_en_tx && jitter_en_rx))
    else $error("both positions on");
  a_alarm_gate: assert property (wr_g |=>
    rx_alarm_insert == (los_ch & {8{$past(pwdata[6])}})) else $error("alarm gating wrong");
  a_pa_hold: assert property (!phase_access && !wr_w |=>
    $stable(phase_sample_address)) else $error("phase address moved");
  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++) begin : g_spu
      wire [3:0] ck = pulse_shape_code[4*k +: 4];
      wire [4:0] sk = samples_per_ui[5*k +: 5];
      a_spu_e1: assert property ((ck == 4'h0 || ck == 4'h8) |-> sk == 5'h0c)
        else $error("e1 samples wrong");
      a_spu_ds1: assert property ((ck == 4'h1 || ck == 4'h2) |-> sk == 5'h0e)
        else $error("ds1 samples wrong");
      a_spu_len: assert property ((ck >= 4'h3 && ck <= 4'h7) |-> sk == 5'h0d)
        else $error("cable samples wrong");
    end
  endgenerate
  c_global_wr: cover property (wr_g);
  c_phase_acc: cover property (phase_access);
  c_e1_75: cover property (c0 == 4'h8);
endmodule

bind lgpc_regs lgpc_regs_asserts u_chk (
  .clk_sys              (clk_sys),
  .nrst                 (nrst),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pwdata               (pwdata),
  .pstrb                (pstrb),
  .los_ch               (los_ch),
  .phase_access         (phase_access),
  .rx_alarm_insert      (rx_alarm_insert),
  .line_code_select     (line_code_select),
  .jitter_fifo_depth    (jitter_fifo_depth),
  .jitter_en_tx         (jitter_en_tx),
  .jitter_en_rx         (jitter_en_rx),
  .phase_sample_address (phase_sample_address),
  .pulse_shape_code     (pulse_shape_code),
  .samples_per_ui       (samples_per_ui)
);

// file: sim/lgpc_host.sv
// Purpose: apb host model for the config bank
// Assumes: slave answers with pready
// Notes:   one idle cycle between transfers
module lgpc_host
  import lgpc_pkg::*;
(
  input  wire logic              clk_sys,
  output      logic              psel,
  output      logic              penable,
  output      logic              pwrite,
  output      logic [ADDR_W+1:0] paddr,
  output      logic [DATA_W-1:0] pwdata,
  output      logic [3:0]        pstrb,
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] q;
  logic              e;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end
  task xfer(input logic [ADDR_W+1:0] a, input logic w, input logic [7:0] d);
    int         n;
    logic [7:0] v;
    v = d;
    if (a == 10'h3c) v[5] = 1'b0;
    if (a == 10'h40) v[7:3] = 5'h00;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, v};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!pready && n < 50);
    if (!pready) begin
      test_liu_global_and_pulse_shape_config.error_cnt++;
      test_liu_global_and_pulse_shape_config.end_sim();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the write land before the caller looks at outputs
      #1;
    end
  endtask
endmodule

// file: sim/test_liu_global_and_pulse_shape_config.sv
// Purpose: register-level test of the config bank
// Assumes: byte address four times the register index
// Notes:   host model drives apb, bench drives line inputs
module test_liu_global_and_pulse_shape_config
  import lgpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        nrst, psel, penable, pwrite, pready, pslverr, phase_access;
  logic        line_code_select, jitter_corner_select, jitter_en_tx, jitter_en_rx;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, pulse_shape_code, e_code;
  logic [3:0]  pstrb;
  logic [7:0]  los_ch, rx_alarm_insert, impedance_internal_select, e_imp, v;
  logic [6:0]  jitter_fifo_depth;
  logic [2:0]  waveform_target_channel;
  logic [4:0]  phase_sample_address;
  logic [39:0] samples_per_ui, e_spu;
  logic [7:0]  gv [4] = '{8'h4d, 8'h13, 8'h46, 8'h00};
  int          error_cnt = 0;
  int          tests_run = 0;
  lgpc_regs dut (
    .clk_sys                   (clk_sys),
    .nrst                      (nrst),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .pstrb                     (pstrb),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .los_ch                    (los_ch),
    .phase_access              (phase_access),
    .rx_alarm_insert           (rx_alarm_insert),
    .line_code_select          (line_code_select),
    .jitter_fifo_depth         (jitter_fifo_depth),
    .jitter_corner_select      (jitter_corner_select),
    .jitter_en_tx              (jitter_en_tx),
    .jitter_en_rx              (jitter_en_rx),
    .waveform_target_channel   (waveform_target_channel),
    .phase_sample_address      (phase_sample_address),
    .impedance_internal_select (impedance_internal_select),
    .pulse_shape_code          (pulse_shape_code),
    .samples_per_ui            (samples_per_ui)
  );
  lgpc_host h (
    .clk_sys (clk_sys),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );
  always #10 clk_sys = ~clk_sys;
  task chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [4:0] spu(input logic [3:0] c);
    if (c == 4'h0 || c == 4'h8) return 5'h0c;
    if (c < 4'h3) return 5'h0e;
    return (c < 4'h8) ? 5'h0d : 5'h00;
  endfunction
  task pulse;
    @(posedge clk_sys) phase_access <= 1'b1;
    @(posedge clk_sys) phase_access <= 1'b0;
    #1;
  endtask
  task shp_chk;
    chk(pulse_shape_code, e_code);
    chk(samples_per_ui, e_spu);
    chk(impedance_internal_select, e_imp);
  endtask
  initial begin
    nrst = 1'b0;
    los_ch = 8'ha5;
    phase_access = 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      h.xfer(10'h3c + 10'(4 * i), 1'b0, 8'h00);
      chk(h.q, 40'h0);
    end
    chk({jitter_fifo_depth, line_code_select}, {7'h20, 1'b0});
    $display("reset test done");
    foreach (gv[i]) begin
      v = gv[i];
      h.xfer(10'h3c, 1'b1, v);
      h.xfer(10'h3c, 1'b0, 8'h00);
      chk(h.q, v);
      chk({rx_alarm_insert, line_code_select, jitter_fifo_depth, jitter_corner_select,
           jitter_en_tx, jitter_en_rx}, {los_ch & {8{v[6]}}, v[4], v[3] ? 7'h40 : 7'h20,
           v[2], v[1:0] == 2'h1, v[1:0] == 2'h3});
    end
    $display("global test done");
    for (int c = 0; c < 8; c++) begin
      h.xfer(10'h40, 1'b1, 8'(c));
      h.xfer(10'h44, 1'b1, 8'(c + 16 * (c % 2)));
    end
    for (int c = 0; c < 8; c++) begin
      h.xfer(10'h40, 1'b1, 8'(c));
      h.xfer(10'h44, 1'b0, 8'h00);
      chk(h.q, 40'(c + 16 * (c % 2)));
      e_code[4*c+:4] = 4'(c);
      e_spu[5*c+:5] = spu(4'(c));
      e_imp[c] = c[0];
    end
    shp_chk();
    h.xfer(10'h40, 1'b1, 8'h00);
    h.xfer(10'h44, 1'b1, 8'h18);
    e_code[3:0] = 4'h8;
    e_spu[4:0] = 5'h0c;
    e_imp[0] = 1'b1;
    shp_chk();
    h.xfer(10'h40, 1'b1, 8'h07);
    h.xfer(10'h44, 1'b1, 8'h0f);
    h.xfer(10'h44, 1'b0, 8'h00);
    chk(h.q, 40'h0f);
    e_code[31:28] = 4'hf;
    e_spu[39:35] = 5'h00;
    e_imp[7] = 1'b0;
    shp_chk();
    $display("shape test done");
    h.xfer(10'h3c, 1'b1, 8'h80);
    h.xfer(10'h5c, 1'b1, 8'hbe);
    chk({waveform_target_channel, phase_sample_address}, 40'hbe);
    pulse();
    chk(phase_sample_address, 40'h1f);
    pulse();
    chk({waveform_target_channel, phase_sample_address}, 40'ha0);
    h.xfer(10'h3c, 1'b1, 8'h00);
    pulse();
    chk(phase_sample_address, 40'h00);
    h.xfer(10'h004, 1'b0, 8'h00);
    chk({h.e, h.q}, 40'h1_0000_0000);
    $display("waveform and unmapped test done");
    h.xfer(10'h3c, 1'b1, 8'h5f);
    @(posedge clk_sys) nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    h.xfer(10'h3c, 1'b0, 8'h00);
    chk(h.q, 40'h0);
    chk({jitter_fifo_depth, pulse_shape_code}, {7'h20, 32'h0});
    chk({waveform_target_channel, phase_sample_address}, 40'h0);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
